// >>> scb_i2c_mst.sv
// bus master model for the two-wire control port
`timescale 1ns/10ps
module scb_i2c_mst (
	input wire clk,
	input wire sda_line,
	output reg scl,
	output reg sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// one bit, 160 ns period, data moves mid-low
	task automatic bit_io(input logic b, output logic s);
		scl <= 1'b0;
		repeat (4) @(posedge clk);
		sda_low <= !b;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		s = sda_line;
		repeat (4) @(posedge clk);
	endtask
	// go=1 start, go=0 stop
	task automatic cond(input logic go);
		logic s;
		bit_io(go, s);
		sda_low <= go;
		repeat (8) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task automatic rd(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(nack, s);
	endtask
endmodule

// >>> scb_irq_pulse.v
// interrupt source selection and fixed-width pulse generator
`timescale 1ns/10ps
`include "scb_regs.vh"

module scb_irq_pulse #(
	parameter PULSE_CYC = `SCB_IRQ_PULSE_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire src_ffsk,
	input wire ffsk_single,
	input wire subaudio_rx_dir,
	input wire [1:0] subaudio_mode_field,
	input wire subtx_sync_evt,
	input wire subrx_level,
	input wire fifo_bit_evt,
	input wire fifo_byte_evt,
	output reg irq_pulse_pin_n
);

	// ----------------------------------------------------------------
	// event selection
	// ----------------------------------------------------------------
	reg subrx_prev;
	reg [9:0] count;
	reg sub_ev;
	reg ev;
	wire rx_rise = subrx_level & ~subrx_prev;
	wire rx_fall = ~subrx_level & subrx_prev;

	always @* begin
		sub_ev = 1'b0;
		if (subaudio_rx_dir) begin
			case (subaudio_mode_field) // RQ9
				`SCB_SA_RISE: sub_ev = rx_rise;
				`SCB_SA_FALL: sub_ev = rx_fall;
				`SCB_SA_BOTH: sub_ev = rx_rise | rx_fall;
				default: sub_ev = 1'b0;
			endcase
		end else begin
			sub_ev = (subaudio_mode_field == `SCB_SA_NRZ_SYNC) & subtx_sync_evt; // RQ10 RQ8
		end
		if (src_ffsk) begin // RQ6
			ev = ffsk_single ? fifo_bit_evt : fifo_byte_evt; // RQ7
		end else begin
			ev = sub_ev;
		end
	end

	// ----------------------------------------------------------------
	// pulse timer
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			subrx_prev <= 1'b0;
			count <= 10'h000;
			irq_pulse_pin_n <= 1'b1;
		end else begin
			subrx_prev <= subrx_level;
			if (count != 10'h000) begin
				count <= count - 10'h001; // RQ15
				if (count == 10'h001) begin
					irq_pulse_pin_n <= 1'b1; // RQ15
				end
			end else if (ev) begin
				count <= PULSE_CYC[9:0]; // RQ5
				irq_pulse_pin_n <= 1'b0; // RQ5
			end
		end
	end

endmodule

// >>> scb_regs.vh
// constants for the serial control port and interrupt pulse logic
`ifndef SCB_REGS_VH
`define SCB_REGS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SCB_CLK_MHZ 100
`define SCB_BUS_MAX_KHZ 400
`define SCB_IRQ_PULSE_NS 8700
`define SCB_IRQ_PULSE_CYC ((`SCB_IRQ_PULSE_NS * `SCB_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------
`define SCB_DEV_ADDR_HI 6'h0c
`define SCB_MODE_AUTO 3'h0
`define SCB_MODE_FIXED 3'h7
`define SCB_REG_COUNT 24

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SCB_REG_AUDIO_ROUTING_A 5'h00
`define SCB_REG_AUDIO_ROUTING_B 5'h01
`define SCB_REG_SUBAUDIO_RECTIFIER_CTRL 5'h02
`define SCB_REG_CTCSS_LO 5'h03
`define SCB_REG_GAIN_FIRST 5'h07
`define SCB_REG_GAIN_LAST 5'h0a
`define SCB_REG_FFSK_CTRL 5'h11
`define SCB_REG_CLK_IRQ_CTRL 5'h13
`define SCB_REG_ADC_RESULT 5'h16
`define SCB_REG_DAC_CODE 5'h17
`define SCB_REG_LAST 5'h17

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCB_HPF_SUPPRESS_BIT 7
`define SCB_SUBAUDIO_DIR_BIT 4
`define SCB_SUBAUDIO_MODE_MSB 3
`define SCB_SUBAUDIO_MODE_LSB 2
`define SCB_FFSK_SINGLE_BIT 4
`define SCB_IRQ_SRC_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SCB_RST_DEFAULT 8'h00
`define SCB_RST_SUBAUDIO 8'he0
`define SCB_RST_CTCSS_LO 8'h5b
`define SCB_RST_GAIN 8'h88

// ----------------------------------------------------------------
// sub-audio mode field codes
// ----------------------------------------------------------------
`define SCB_SA_RISE 2'h0
`define SCB_SA_FALL 2'h1
`define SCB_SA_BOTH 2'h2
`define SCB_SA_NRZ_SYNC 2'h1

`endif

// >>> scb_serial_ctrl.v
// serial control port slave, register file and interrupt pin
// ----------------------------------------------------------------
// Notes on behaviour
// (RQ1) two-wire slave, read and write, 400 kHz
// (RQ2) address 001100X, X from select pin
// (RQ3) auto mode steps pointer, wraps after 17h
// (RQ4) mode bits 000 auto, 111 fixed pointer
// (RQ5) one low pulse about 8.7 us
// (RQ6) reg 13h bit0 picks sub-audio or FFSK
// (RQ7) reg 11h bit4: eight bits or one
// (RQ8) reg 02h bit4 picks transmitter or detector
// (RQ9) detector edges: rising, falling, both
// (RQ10) transmitter interrupts only in NRZ sync
// (RQ11) reg 01h bit7 filter suppression, reset 0
// (RQ12) sources chosen only by bus writes
// (RQ13) fixed mode: repeated DAC bytes, no re-address
// (RQ14) fixed mode: repeated ADC reads, no re-address
// (RQ15) pulse timed by clock count, idles high
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "scb_regs.vh"

module scb_serial_ctrl #(
	parameter IRQ_PULSE_CYC = `SCB_IRQ_PULSE_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire addr_sel_pin,
	input wire [7:0] adc_result,
	input wire subtx_sync_evt,
	input wire subrx_level,
	input wire fifo_bit_evt,
	input wire fifo_byte_evt,
	output wire irq_pulse_pin_n,
	output reg [7:0] audio_routing_a,
	output reg [7:0] audio_routing_b,
	output reg [7:0] subaudio_rectifier_ctrl,
	output reg [7:0] dac_code,
	output reg hpf_suppress
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_SUB = 3'h2;
	localparam S_WDATA = 3'h3;
	localparam S_RDATA = 3'h4;
	localparam S_ACK = 3'h5;
	localparam S_RACK = 3'h6;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function mapped;
		input [4:0] p;
		begin
			mapped = (p <= `SCB_REG_LAST);
		end
	endfunction

	function [4:0] step_ptr;
		input [4:0] p;
		input fixed;
		begin
			if (fixed) begin
				step_ptr = p; // RQ4 RQ13 RQ14
			end else if (p >= `SCB_REG_LAST) begin
				step_ptr = 5'h00; // RQ3
			end else begin
				step_ptr = p + 5'h01; // RQ3
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg scl_m, scl_s, scl_d;
	reg sda_m, sda_s, sda_d, sda_dd;
	reg asel_m, asel_s;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			sda_dd <= 1'b1;
			asel_m <= 1'b0;
			asel_s <= 1'b0;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_d <= sda_s;
			sda_dd <= sda_d;
			asel_m <= addr_sel_pin;
			asel_s <= asel_m;
		end
	end

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	// start and stop see sda one stage later, so skew against scl cannot fake them
	wire bus_start = scl_s & scl_d & sda_dd & ~sda_d;
	wire bus_stop = scl_s & scl_d & ~sda_dd & sda_d;

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	reg [7:0] regs [0:`SCB_REG_COUNT-1];
	reg [2:0] state;
	reg [2:0] ack_next;
	reg ack_on;
	reg [2:0] bitcnt;
	reg [7:0] shreg;
	reg [4:0] ptr;
	reg fixed_mode;
	reg [7:0] rd_byte;
	wire [7:0] in_byte = {shreg[6:0], sda_s};
	integer i;

	always @* begin
		rd_byte = 8'h00;
		if (ptr == `SCB_REG_ADC_RESULT) begin
			rd_byte = adc_result; // RQ14
		end else if (mapped(ptr)) begin
			rd_byte = regs[ptr];
		end
	end

	// ----------------------------------------------------------------
	// bus slave state machine
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			ack_next <= S_IDLE;
			ack_on <= 1'b0;
			bitcnt <= 3'h0;
			shreg <= 8'h00;
			ptr <= 5'h00;
			fixed_mode <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			for (i = 0; i < `SCB_REG_COUNT; i = i + 1) begin
				regs[i] <= `SCB_RST_DEFAULT; // RQ11
			end
			regs[`SCB_REG_SUBAUDIO_RECTIFIER_CTRL] <= `SCB_RST_SUBAUDIO;
			regs[`SCB_REG_CTCSS_LO] <= `SCB_RST_CTCSS_LO;
			for (i = `SCB_REG_GAIN_FIRST; i <= `SCB_REG_GAIN_LAST; i = i + 1) begin
				regs[i] <= `SCB_RST_GAIN;
			end
		end else begin
			sda_out <= 1'b0;
			if (bus_start) begin
				state <= S_ADDR; // RQ1
				bitcnt <= 3'h0;
				ack_on <= 1'b0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state <= S_IDLE;
				ack_on <= 1'b0;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					S_ADDR, S_SUB, S_WDATA: begin
						if (scl_rise) begin
							shreg <= in_byte;
							bitcnt <= bitcnt + 3'h1;
							if (bitcnt == 3'h7) begin
								state <= S_ACK;
								if (state == S_ADDR) begin
									if (in_byte[7:1] == {`SCB_DEV_ADDR_HI, asel_s}) begin // RQ2
										ack_next <= in_byte[0] ? S_RDATA : S_SUB;
									end else begin
										state <= S_IDLE;
									end
								end else if (state == S_SUB) begin
									fixed_mode <= (in_byte[7:5] == `SCB_MODE_FIXED); // RQ4
									ptr <= in_byte[4:0];
									ack_next <= S_WDATA;
								end else begin
									if (mapped(ptr)) begin
										regs[ptr] <= in_byte; // RQ12 RQ13
									end
									ptr <= step_ptr(ptr, fixed_mode); // RQ3 RQ13
									ack_next <= S_WDATA;
								end
							end
						end
					end
					// first fall pulls sda, second fall moves on and releases sda, or drives bit 7 of rd_byte when going to S_RDATA
					S_ACK: begin
						if (scl_fall) begin
							if (!ack_on) begin
								ack_on <= 1'b1;
								sda_oe <= 1'b1;
							end else begin
								ack_on <= 1'b0;
								bitcnt <= 3'h0;
								state <= ack_next;
								if (ack_next == S_RDATA) begin
									shreg <= rd_byte;
									sda_oe <= ~rd_byte[7];
								end else begin
									sda_oe <= 1'b0;
								end
							end
						end
					end
					S_RDATA: begin
						if (scl_fall) begin
							bitcnt <= bitcnt + 3'h1;
							if (bitcnt == 3'h7) begin
								sda_oe <= 1'b0;
								state <= S_RACK;
								ptr <= step_ptr(ptr, fixed_mode); // RQ3 RQ14
							end else begin
								shreg <= {shreg[6:0], 1'b0};
								sda_oe <= ~shreg[6];
							end
						end
					end
					// master ack at the rise decides whether another byte follows
					S_RACK: begin
						if (scl_rise) begin
							ack_on <= ~sda_s;
							if (sda_s) begin
								state <= S_IDLE;
							end
						end else if (scl_fall && ack_on) begin
							ack_on <= 1'b0;
							bitcnt <= 3'h0;
							state <= S_RDATA;
							shreg <= rd_byte;
							sda_oe <= ~rd_byte[7];
						end
					end
					default: begin
						state <= S_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// register outputs
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			audio_routing_a <= `SCB_RST_DEFAULT;
			audio_routing_b <= `SCB_RST_DEFAULT;
			subaudio_rectifier_ctrl <= `SCB_RST_SUBAUDIO;
			dac_code <= `SCB_RST_DEFAULT;
			hpf_suppress <= 1'b0;
		end else begin
			audio_routing_a <= regs[`SCB_REG_AUDIO_ROUTING_A];
			audio_routing_b <= regs[`SCB_REG_AUDIO_ROUTING_B];
			subaudio_rectifier_ctrl <= regs[`SCB_REG_SUBAUDIO_RECTIFIER_CTRL];
			dac_code <= regs[`SCB_REG_DAC_CODE]; // RQ13
			hpf_suppress <= regs[`SCB_REG_AUDIO_ROUTING_B][`SCB_HPF_SUPPRESS_BIT]; // RQ11
		end
	end

	// ----------------------------------------------------------------
	// interrupt pin
	// ----------------------------------------------------------------
	// fields that steer the interrupt source
	wire [7:0] sa_reg = regs[`SCB_REG_SUBAUDIO_RECTIFIER_CTRL];
	wire src_ffsk = regs[`SCB_REG_CLK_IRQ_CTRL][`SCB_IRQ_SRC_BIT]; // RQ6
	wire ffsk_single = regs[`SCB_REG_FFSK_CTRL][`SCB_FFSK_SINGLE_BIT]; // RQ7
	wire subaudio_rx_dir = sa_reg[`SCB_SUBAUDIO_DIR_BIT]; // RQ8
	wire [1:0] subaudio_mode_field = sa_reg[`SCB_SUBAUDIO_MODE_MSB:`SCB_SUBAUDIO_MODE_LSB]; // RQ9

	scb_irq_pulse #(
		.PULSE_CYC(IRQ_PULSE_CYC)
	) u_irq (
		.clk(clk),
		.rst_n(rst_n),
		.src_ffsk(src_ffsk),
		.ffsk_single(ffsk_single),
		.subaudio_rx_dir(subaudio_rx_dir),
		.subaudio_mode_field(subaudio_mode_field),
		.subtx_sync_evt(subtx_sync_evt),
		.subrx_level(subrx_level),
		.fifo_bit_evt(fifo_bit_evt),
		.fifo_byte_evt(fifo_byte_evt),
		.irq_pulse_pin_n(irq_pulse_pin_n)
	);

endmodule

// >>> scb_serial_ctrl_sva.sv
// pin-level assertions for the serial control port
`timescale 1ns/10ps
module scb_serial_ctrl_sva #(
	parameter IRQ_PULSE_CYC = 870
) (
	input wire clk,
	input wire rst_n,
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe,
	input wire subtx_sync_evt,
	input wire subrx_level,
	input wire fifo_bit_evt,
	input wire fifo_byte_evt,
	input wire irq_pulse_pin_n,
	input wire [7:0] audio_routing_a,
	input wire [7:0] audio_routing_b,
	input wire [7:0] dac_code,
	input wire hpf_suppress
);
	reg [10:0] low_cnt;
	reg lvl_d;
	wire cause = subtx_sync_evt | fifo_bit_evt | fifo_byte_evt | (subrx_level ^ lvl_d);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= 11'h000;
			lvl_d <= 1'b0;
		end else begin
			low_cnt <= irq_pulse_pin_n ? 11'h000 : low_cnt + 11'h001;
			lvl_d <= subrx_level;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----
	// properties
	// ----
	property p_irq_len; $rose(irq_pulse_pin_n) |-> low_cnt == IRQ_PULSE_CYC; endproperty
	a_irq_len: assert property (p_irq_len) else $error("irq pulse width wrong");
	property p_irq_max; low_cnt <= IRQ_PULSE_CYC; endproperty
	a_irq_max: assert property (p_irq_max) else $error("irq pulse too long");
	property p_irq_cause; $fell(irq_pulse_pin_n) |-> $past(cause) || $past(cause, 2); endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
	property p_sda_out; sda_out == 1'b0; endproperty
	a_sda_out: assert property (p_sda_out) else $error("sda driven high");
	property p_oe_rise; $rose(sda_oe) |-> !scl_in; endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("sda pulled in clock high");
	property p_oe_fall; $fell(sda_oe) |-> !scl_in; endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("sda freed in clock high");
	property p_oe_stable; scl_in [*4] |-> $stable(sda_oe); endproperty
	a_oe_stable: assert property (p_oe_stable) else $error("sda moved in clock high");
	property p_reg_bus; $changed(audio_routing_a) || $changed(dac_code) |-> scl_in; endproperty
	a_reg_bus: assert property (p_reg_bus) else $error("register moved off bus");
	property p_hpf; hpf_suppress == audio_routing_b[7]; endproperty
	a_hpf: assert property (p_hpf) else $error("filter bit mismatch");
	c_irq: cover property ($fell(irq_pulse_pin_n));
	c_ack: cover property ($rose(sda_oe));
	c_dac: cover property ($changed(dac_code));
endmodule

// >>> scb_serial_ctrl_tb_top.sv
// top-level bench for the serial control port
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
	$display("BAD %s exp %0h got %0h", n, e, a); end end
module scb_serial_ctrl_tb_top;
	localparam int PW = 8;
	logic clk, rst_n, sel, lvl;
	logic [2:0] evt;
	logic [7:0] adc;
	int err_total = 0, check_count = 0;
	wire scl, sda_low, sda_oe, irq_n, hpf;
	wire sda = !(sda_low || sda_oe);
	wire [7:0] ra, rb, rc, dac;
	initial clk = 1'b0;
	always #5 clk = ~clk;
	scb_i2c_mst u_mst (.clk(clk), .sda_line(sda), .scl(scl), .sda_low(sda_low));
	scb_serial_ctrl #(.IRQ_PULSE_CYC(PW)) u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl),
		.sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_sel_pin(sel), .adc_result(adc),
		.subtx_sync_evt(evt[0]), .subrx_level(lvl), .fifo_bit_evt(evt[1]),
		.fifo_byte_evt(evt[2]), .irq_pulse_pin_n(irq_n), .audio_routing_a(ra),
		.audio_routing_b(rb), .subaudio_rectifier_ctrl(rc), .dac_code(dac),
		.hpf_suppress(hpf));
	// ----
	// bus helpers
	// ----
	task automatic wb(input logic [7:0] d);
		logic a;
		u_mst.wr(d, a);
		`CHK("ack", 1'b1, a)
	endtask
	task automatic hdr(input logic [7:0] sub);
		u_mst.cond(1'b1);
		wb({6'h0c, sel, 1'b0});
		wb(sub);
	endtask
	task automatic wreg(input logic [7:0] sub, input logic [7:0] d);
		hdr(sub);
		wb(d);
		u_mst.cond(1'b0);
	endtask
	task automatic fire(input logic [7:0] i, input logic x);
		int n;
		n = 0;
		if (i == 8'h03) lvl <= !lvl;
		else evt[i] <= 1'b1;
		@(posedge clk) evt <= 3'h0;
		repeat (PW + 6) @(posedge clk) n += !irq_n;
		`CHK("irq low cycles", x ? PW : 0, n)
		`CHK("irq idle", 1'b1, irq_n)
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		`CHK("reset regs", 32'h0000e000, {ra, rb, rc, dac})
		`CHK("reset pins", 3'h4, {irq_n, hpf, sda_oe})
		$display("reset test done");
	endtask
	task automatic t_addr;
		logic a;
		u_mst.cond(1'b1);
		u_mst.wr({6'h0c, !sel, 1'b0}, a);
		`CHK("foreign address ack", 1'b0, a)
		u_mst.cond(1'b0);
		sel <= 1'b1;
		repeat (4) @(posedge clk);
		wreg(8'h00, 8'h5a);
		`CHK("routing a", 8'h5a, ra)
		sel <= 1'b0;
		repeat (4) @(posedge clk);
		$display("addr test done");
	endtask
	task automatic t_auto;
		hdr(8'h00);
		wb(8'h81);
		wb(8'h82);
		wb(8'h13);
		u_mst.cond(1'b0);
		`CHK("auto regs", 25'h1030427, {ra, rb, rc, hpf})
		hdr(8'h17);
		wb(8'h44);
		wb(8'h55);
		u_mst.cond(1'b0);
		`CHK("wrap", 16'h4455, {dac, ra})
		$display("auto test done");
	endtask
	task automatic t_fixed;
		hdr(8'hf7);
		for (int i = 1; i < 4; i++) begin
			wb(8'(i));
			`CHK("dac fixed", 8'(i), dac)
		end
		u_mst.cond(1'b0);
		`CHK("routing a kept", 8'h55, ra)
		$display("fixed test done");
	endtask
	task automatic t_adc;
		logic [7:0] d;
		hdr(8'hf6);
		u_mst.cond(1'b1);
		wb({6'h0c, sel, 1'b1});
		u_mst.rd(1'b0, d);
		`CHK("adc first", 8'h3c, d)
		adc <= 8'hc5;
		u_mst.rd(1'b1, d);
		`CHK("adc second", 8'hc5, d)
		u_mst.cond(1'b0);
		$display("adc test done");
	endtask
	task automatic t_irq;
		logic [31:0] tbl [15] = '{32'h13010201, 32'h11000100, 32'h11100101,
			32'h13000100, 32'h02040001, 32'h020c0000, 32'h02000000,
			32'h02100301, 32'h02100300, 32'h02140300, 32'h02140301,
			32'h02180301, 32'h02180301, 32'h02080000,
			32'h021c0300};
		foreach (tbl[k]) begin
			wreg(tbl[k][31:24], tbl[k][23:16]);
			fire(tbl[k][15:8], tbl[k][0]);
		end
		$display("irq test done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		sel = 1'b0;
		lvl = 1'b0;
		evt = 3'h0;
		adc = 8'h3c;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_reset;
		t_addr;
		t_auto;
		t_fixed;
		t_adc;
		t_irq;
		print_verdict;
	end
	initial begin
		#500000;
		err_total++;
		print_verdict;
	end
endmodule
bind scb_serial_ctrl scb_serial_ctrl_sva #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) u_sva (.clk, .rst_n,
	.scl_in, .sda_out, .sda_oe, .subtx_sync_evt, .subrx_level, .fifo_bit_evt, .fifo_byte_evt,
	.irq_pulse_pin_n, .audio_routing_a, .audio_routing_b, .dac_code, .hpf_suppress);
